// ### rtl/ecl_pkg.sv
// package: constants, types and register map for the eeprom config loader
package ecl_pkg;
  // register addresses on the serial path (one word per address)
  localparam logic [7:0] ADDR_PORT45_VID = 8'h2a;
  localparam logic [7:0] ADDR_PORT67_VID = 8'h2b;
  localparam logic [7:0] ADDR_EXP_VLAN_CTRL = 8'h2c;
  localparam logic [7:0] ADDR_SIGNATURE = 8'h00;
  // reset values
  localparam logic [15:0] RST_PORT_VID = 16'h0000;
  localparam logic [15:0] RST_EXP_VLAN_CTRL = 16'hd000;
  // signature word that marks a valid eeprom image (arbitrary value)
  localparam logic [15:0] EEPROM_SIGNATURE = 16'h4154;
  // field positions of the group control register
  localparam int FWD_HI_BIT = 15;
  localparam int FWD_MID_BIT = 14;
  localparam int FWD_ONE_BIT = 13;
  localparam int FWD_ZERO_BIT = 12;
  localparam int GROUP_CNT_BIT = 11;
  localparam int SHIFT_HI = 10;
  localparam int SHIFT_LO = 8;
  localparam int VID_HI_W = 8;
  // serial eeprom instruction: start bit, 2 opcode bits, 8 address bits, 16 data
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int LAST_LOAD_ADDR = 63;
  // timing at 200 MHz
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STRAP_DELAY_NS = 200;
  localparam int LOAD_DELAY_NS = 800;
  localparam int STRAP_CYC = (STRAP_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOAD_CYC = (LOAD_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOAD_WINDOW_MS = 30;
  localparam int SK_HALF_CYC = 16;
  // strap values latched after reset
  typedef struct packed {
    logic auto_crossover;
    logic dual_colour;
    logic load_enable;
  } ecl_strap_s;
  // a decoded register write
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ecl_wr_s;
endpackage

// ### rtl/ecl_snoop.sv
// module: shifts in serial eeprom instructions and reports write commands
`timescale 1ns/1ps
module ecl_snoop (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // synchronised serial bus: select and data levels, sk rising-edge strobe
  input wire logic cs_i,
  input wire logic sk_rise_i,
  input wire logic di_i,
  // decoded write
  output ecl_pkg::ecl_wr_s wr_o
);
  localparam int FRAME_W = 3 + ecl_pkg::ADDR_W + ecl_pkg::DATA_W;
  logic [FRAME_W-1:0] shift_q;
  logic [5:0] cnt_q;
  logic done_q;
  ecl_pkg::ecl_wr_s wr_q;

  // collect bits while select is high; one frame per select cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= '0;
      cnt_q <= 6'h00;
      done_q <= 1'b0;
    end else if (!cs_i) begin
      cnt_q <= 6'h00;
      done_q <= 1'b0;
    end else if (sk_rise_i && !done_q) begin
      if (cnt_q != 6'h00 || di_i) begin
        shift_q <= {shift_q[FRAME_W-2:0], di_i};
        cnt_q <= cnt_q + 6'h01;
        done_q <= (cnt_q == 6'(FRAME_W - 1));
      end
    end
  end

  // only a complete write frame yields an update; others ignored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
    end else begin
      wr_q.valid <= 1'b0;
      if (cs_i && sk_rise_i && !done_q && cnt_q == 6'(FRAME_W - 1)
          && shift_q[FRAME_W-3 -: 2] == ecl_pkg::OP_WRITE) begin
        wr_q.valid <= 1'b1;
        // address sits between the opcode and the 15 data bits already shifted
        wr_q.addr <= shift_q[ecl_pkg::DATA_W+ecl_pkg::ADDR_W-2 -: ecl_pkg::ADDR_W];
        wr_q.data <= {shift_q[ecl_pkg::DATA_W-2:0], di_i};
      end
    end
  end

  assign wr_o = wr_q;
endmodule // ecl_snoop

// ### rtl/ecl_loader.sv
// module: eeprom configuration loader and vlan configuration registers
`timescale 1ns/1ps
module ecl_loader #(
  parameter int LOAD_WINDOW_CYC = ecl_pkg::LOAD_WINDOW_MS * 200000
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // eeprom pins
  input wire logic eeprom_select_i,
  output logic eeprom_select_o,
  output logic eeprom_select_oe_o,
  input wire logic eeprom_serial_clock_i,
  output logic eeprom_serial_clock_o,
  output logic eeprom_serial_clock_oe_o,
  input wire logic eeprom_data_in_i,
  output logic eeprom_data_in_o,
  output logic eeprom_data_in_oe_o,
  input wire logic eeprom_data_out_i,
  // per-port low vid bits 13..10 of own control registers, ports 4..8
  input wire logic [19:0] port_vid_low_i,
  // configuration results
  output logic [59:0] port_default_vlan_id_o,
  output logic [3:0] reserved_addr_forward_o,
  output logic vlan_group_count_sel_o,
  output logic [2:0] vlan_shift_o,
  output logic [11:0] frame_vid_i_unused_o,
  output ecl_pkg::ecl_strap_s strap_o,
  output logic load_busy_o,
  // group index lookup from a frame vid
  input wire logic [11:0] frame_vid_i,
  output logic [4:0] vlan_group_o
);
  typedef enum {ST_STRAP, ST_WAIT, ST_SEND, ST_RECV, ST_GAP, ST_IDLE} ecl_state_e;
  // =====================================================================
  // reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic sk_prev_q;
  // two flops per pin: select, sk, di, do
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      sk_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {eeprom_select_i, eeprom_serial_clock_i, eeprom_data_in_i, eeprom_data_out_i};
      pin_s2_q <= pin_s1_q;
      sk_prev_q <= pin_s2_q[2];
    end
  end

  // =====================================================================
  // power-up sequencer
  ecl_state_e state_q;
  logic [31:0] time_q;
  logic [31:0] win_q;
  logic [5:0] bit_q;
  logic [5:0] addr_q;
  logic [15:0] rd_q;
  logic [26:0] cmd_q;
  logic sk_q;
  logic [4:0] half_q;
  logic sig_ok_q;
  ecl_pkg::ecl_strap_s strap_q;
  ecl_pkg::ecl_wr_s load_wr;
  logic sk_tick;
  assign sk_tick = (half_q == 5'(ecl_pkg::SK_HALF_CYC - 1));

  // window counter from reset release
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) win_q <= '0;
    else if (win_q != 32'(LOAD_WINDOW_CYC)) win_q <= win_q + 32'd1;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_STRAP;
      time_q <= '0;
      bit_q <= '0;
      addr_q <= '0;
      rd_q <= '0;
      cmd_q <= '0;
      sk_q <= 1'b0;
      half_q <= '0;
      sig_ok_q <= 1'b0;
      strap_q <= '{1'b0, 1'b0, 1'b1};
    end else begin
      time_q <= time_q + 32'd1;
      half_q <= sk_tick ? 5'd0 : half_q + 5'd1;
      case (state_q)
        ST_STRAP: begin
          if (time_q == 32'(ecl_pkg::STRAP_CYC)) begin
            strap_q <= '{pin_s2_q[2], pin_s2_q[1], pin_s2_q[0]};
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (time_q == 32'(ecl_pkg::LOAD_CYC)) begin
            state_q <= strap_q.load_enable ? ST_SEND : ST_IDLE;
            cmd_q <= {1'b1, ecl_pkg::OP_READ, 2'b00, addr_q, 16'h0000};
            bit_q <= '0;
            half_q <= '0;
          end
        end
        ST_SEND, ST_RECV: begin
          if (sk_tick) begin
            sk_q <= !sk_q;
            if (sk_q) begin
              // falling edge: next command bit
              cmd_q <= {cmd_q[25:0], 1'b0};
              if (state_q == ST_SEND && bit_q == 6'd10) begin
                state_q <= ST_RECV;
                bit_q <= '0;
              end else bit_q <= bit_q + 6'd1;
            end else if (state_q == ST_RECV) begin
              rd_q <= {rd_q[14:0], pin_s2_q[0]};
              if (bit_q == 6'd15) state_q <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          sk_q <= 1'b0;
          if (addr_q == 6'(ecl_pkg::ADDR_SIGNATURE))
            sig_ok_q <= (rd_q == ecl_pkg::EEPROM_SIGNATURE);
          if ((addr_q == 6'(ecl_pkg::ADDR_SIGNATURE) && rd_q != ecl_pkg::EEPROM_SIGNATURE)
              || addr_q == 6'(ecl_pkg::LAST_LOAD_ADDR)) begin
            state_q <= ST_IDLE;
          end else begin
            addr_q <= addr_q + 6'd1;
            cmd_q <= {1'b1, ecl_pkg::OP_READ, 2'b00, addr_q + 6'd1, 16'h0000};
            bit_q <= '0;
            state_q <= ST_SEND;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // loaded word becomes a register write once signature is confirmed
  assign load_wr = '{state_q == ST_GAP && addr_q != 6'(ecl_pkg::ADDR_SIGNATURE) && sig_ok_q,
                     {2'b00, addr_q}, rd_q};

  // =====================================================================
  // pin drive: float in reset, drive while loading, inputs after
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_select_oe_o <= 1'b0;
      eeprom_serial_clock_oe_o <= 1'b0;
      eeprom_data_in_oe_o <= 1'b0;
      eeprom_select_o <= 1'b0;
      eeprom_serial_clock_o <= 1'b0;
      eeprom_data_in_o <= 1'b0;
    end else begin
      eeprom_select_oe_o <= state_q inside {ST_SEND, ST_RECV, ST_GAP};
      eeprom_serial_clock_oe_o <= state_q inside {ST_SEND, ST_RECV, ST_GAP};
      eeprom_data_in_oe_o <= state_q inside {ST_SEND, ST_RECV, ST_GAP};
      eeprom_select_o <= state_q inside {ST_SEND, ST_RECV};
      eeprom_serial_clock_o <= sk_q;
      eeprom_data_in_o <= cmd_q[26];
    end
  end

  // =====================================================================
  // host write snoop, active once loading is over and the load window has ended
  ecl_pkg::ecl_wr_s snoop_wr;
  logic snoop_on;
  assign snoop_on = (state_q == ST_IDLE) && (win_q == 32'(LOAD_WINDOW_CYC));
  ecl_snoop u_snoop (
    .clk_i(clock_i),
    .rst_n_i(rst_n),
    .cs_i(pin_s2_q[3] && snoop_on),
    .sk_rise_i(pin_s2_q[2] && !sk_prev_q),
    .di_i(pin_s2_q[1]),
    .wr_o(snoop_wr)
  );

  // =====================================================================
  // configuration registers
  logic [15:0] vid45_q;
  logic [15:0] vid67_q;
  logic [15:0] ctrl_q;
  ecl_pkg::ecl_wr_s wr;
  assign wr = load_wr.valid ? load_wr : snoop_wr;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      vid45_q <= ecl_pkg::RST_PORT_VID;
      vid67_q <= ecl_pkg::RST_PORT_VID;
      ctrl_q <= ecl_pkg::RST_EXP_VLAN_CTRL;
    end else if (wr.valid) begin
      if (wr.addr == ecl_pkg::ADDR_PORT45_VID) vid45_q <= wr.data;
      else if (wr.addr == ecl_pkg::ADDR_PORT67_VID) vid67_q <= wr.data;
      else if (wr.addr == ecl_pkg::ADDR_EXP_VLAN_CTRL) ctrl_q <= wr.data;
    end
  end

  // full vids for ports 4..8: odd port in high byte, even in low
  logic [39:0] vid_hi;
  assign vid_hi = {ctrl_q[ecl_pkg::VID_HI_W-1:0], vid67_q, vid45_q};
  logic [59:0] vid_d;
  for (genvar p = 0; p < 5; p++) begin : g_vid
    assign vid_d[p*12 +: 12] = {vid_hi[p*8 +: 8], port_vid_low_i[p*4 +: 4]};
  end

  // group index from frame vid
  logic [4:0] group_d;
  logic [11:0] vid_sh;
  assign vid_sh = frame_vid_i >> ctrl_q[ecl_pkg::SHIFT_HI:ecl_pkg::SHIFT_LO];
  assign group_d = ctrl_q[ecl_pkg::GROUP_CNT_BIT] ? vid_sh[4:0]
                                                   : {1'b0, vid_sh[3:0]};

  // registered outputs
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      port_default_vlan_id_o <= '0;
      reserved_addr_forward_o <= 4'h0;
      vlan_group_count_sel_o <= 1'b0;
      vlan_shift_o <= 3'h0;
      frame_vid_i_unused_o <= 12'h000;
      strap_o <= '0;
      load_busy_o <= 1'b0;
      vlan_group_o <= 5'h00;
    end else begin
      port_default_vlan_id_o <= vid_d;
      reserved_addr_forward_o <= ctrl_q[ecl_pkg::FWD_HI_BIT:ecl_pkg::FWD_ZERO_BIT];
      vlan_group_count_sel_o <= ctrl_q[ecl_pkg::GROUP_CNT_BIT];
      vlan_shift_o <= ctrl_q[ecl_pkg::SHIFT_HI:ecl_pkg::SHIFT_LO];
      frame_vid_i_unused_o <= vid_sh;
      strap_o <= strap_q;
      load_busy_o <= !snoop_on;
      vlan_group_o <= group_d;
    end
  end
endmodule // ecl_loader

// ### dv/ecl_checker.sv
// checker: port-level properties of the eeprom config loader
`timescale 1ns/1ps
module ecl_chk #(
  parameter int LOAD_WINDOW_CYC = 2000
) (
  // watched ports
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic eeprom_select_oe_o,
  input wire logic eeprom_serial_clock_oe_o,
  input wire logic eeprom_data_in_oe_o,
  input wire logic eeprom_serial_clock_i,
  input wire logic eeprom_data_in_i,
  input wire logic eeprom_data_out_i,
  input wire logic [19:0] port_vid_low_i,
  input wire logic [59:0] port_default_vlan_id_o,
  input wire logic [3:0] reserved_addr_forward_o,
  input wire logic vlan_group_count_sel_o,
  input wire logic [2:0] vlan_shift_o,
  input wire ecl_pkg::ecl_strap_s strap_o,
  input wire logic load_busy_o,
  input wire logic [11:0] frame_vid_i,
  input wire logic [4:0] vlan_group_o
);
  logic [7:0] rel_q;
  logic [11:0] sh;
  // cycles since reset release, saturating
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) rel_q <= 8'h00;
    else if (rel_q != 8'hff) rel_q <= rel_q + 8'h01;
  end
  assign sh = frame_vid_i >> vlan_shift_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // lookup inputs and mode unchanged since the last edge
  sequence s_calm;
    rel_q > 8'd8 && $stable(frame_vid_i) && $stable(vlan_shift_o) && $stable(vlan_group_count_sel_o);
  endsequence
  sequence s_strap_seen;
    rel_q == 8'd60;
  endsequence
  AST_PINS_FLOAT: assert property (disable iff (1'b0) !nrst_i |-> !(eeprom_select_oe_o || eeprom_serial_clock_oe_o || eeprom_data_in_oe_o))
    else $error("eeprom pin driven in reset");
  AST_VID_LOW: assert property ((rel_q > 8'd8 && $stable(port_vid_low_i))[*3] |-> {port_default_vlan_id_o[51:48], port_default_vlan_id_o[39:36], port_default_vlan_id_o[27:24], port_default_vlan_id_o[15:12], port_default_vlan_id_o[3:0]} == port_vid_low_i)
    else $error("low vid bits wrong");
  AST_GRP16: assert property (s_calm[*3] ##0 !vlan_group_count_sel_o |-> vlan_group_o == {1'b0, sh[3:0]})
    else $error("16-group index wrong");
  AST_GRP32: assert property (s_calm[*3] ##0 vlan_group_count_sel_o |-> vlan_group_o == sh[4:0])
    else $error("32-group index wrong");
  AST_RST_CTRL: assert property (rel_q == 8'd8 |-> reserved_addr_forward_o == 4'hd && !vlan_group_count_sel_o && vlan_shift_o == 3'd0)
    else $error("control reset value wrong");
  AST_STRAP: assert property (s_strap_seen |-> strap_o == {eeprom_serial_clock_i, eeprom_data_in_i, eeprom_data_out_i})
    else $error("strap capture wrong");
  AST_STRAP_KEEP: assert property (rel_q > 8'd60 |-> $stable(strap_o))
    else $error("strap changed");
  AST_QUIET_EARLY: assert property (rel_q < 8'd150 |-> !eeprom_select_oe_o && !eeprom_serial_clock_oe_o)
    else $error("eeprom driven too early");
  AST_LOAD_START: assert property (rel_q == 8'd170 && strap_o.load_enable |-> eeprom_select_oe_o && eeprom_serial_clock_oe_o)
    else $error("load not started");
  AST_NO_LOAD: assert property (rel_q == 8'd170 && !strap_o.load_enable |-> !eeprom_select_oe_o)
    else $error("load despite strap");
  AST_RELEASED: assert property (rel_q == 8'hff && !load_busy_o |-> !eeprom_select_oe_o && !eeprom_serial_clock_oe_o)
    else $error("pins driven after load");
endmodule // ecl_chk

// ### dv/ecl_eeprom_model.sv
// model: serial configuration eeprom, with strap level on data-out
`timescale 1ns/1ps
module ecl_eeprom_model (
  // serial bus levels
  input wire logic cs_i,
  input wire logic sk_i,
  input wire logic di_i,
  // scenario controls
  input wire logic bad_sig_i,
  input wire logic strap_do_i,
  // data-out pin level
  output logic do_o
);
  logic [15:0] mem [64];
  logic [10:0] hdr;
  logic [15:0] w;
  logic [5:0] a;
  logic rd;
  logic dq;
  int cnt;
  // image: signature word at 0, config words at 0x2a..0x2c
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    mem[0] = ecl_pkg::EEPROM_SIGNATURE;
    mem[42] = 16'h8c3b;
    mem[43] = 16'h4e71;
    mem[44] = 16'h2a96;
    cnt = 0;
    hdr = '0;
    dq = 1'b1;
  end
  // header shifts in on rising sk, leading zeros skipped
  always @(posedge sk_i or negedge cs_i) begin
    if (!cs_i) cnt = 0;
    else if (cnt > 0 || di_i) begin
      if (cnt < 11) hdr = {hdr[9:0], di_i};
      cnt = cnt + 1;
    end
  end
  assign rd = cs_i && cnt >= 11 && hdr[9:8] == 2'b10;
  // next read bit after each falling sk, running on into later words
  always @(negedge sk_i) begin
    a = 6'(hdr[5:0] + (cnt - 11) / 16);
    w = mem[a] ^ ((a == 6'd0 && bad_sig_i) ? 16'hffff : 16'h0000);
    if (rd) dq = w[15 - (cnt - 11) % 16];
  end
  // idle pin sits at its pull-up, or at the strap level during reset
  assign do_o = rd ? dq : strap_do_i;
endmodule // ecl_eeprom_model

// ### dv/tb_top.sv
// testbench: config load, snooped writes and vlan lookup
`timescale 1ns/1ps
module tb_top;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b1;
  logic h_oe = 1'b1, h_cs = 1'b0, h_sk = 1'b0, h_di = 1'b0, bad = 1'b0, sdo = 1'b1;
  logic [19:0] low = 20'h9c3a5;
  logic [11:0] fvid = 12'hb6d;
  logic [11:0] vsh;
  logic cs_o, cs_oe, sk_o, sk_oe, di_o, di_oe, busy, sel;
  logic [59:0] port_default_vlan_id;
  logic [3:0] fwd;
  logic [2:0] shf;
  logic [4:0] grp;
  logic [15:0] r2a, r2b, r2c;
  ecl_pkg::ecl_strap_s strap;
  wire cs_w, sk_w, di_w, do_w;
  int n_errors = 0;
  int cmp_count = 0;
  // ====================================
  // pins: device, then host, else pull-down
  assign cs_w = cs_oe ? cs_o : (h_oe ? h_cs : 1'b0);
  assign sk_w = sk_oe ? sk_o : (h_oe ? h_sk : 1'b0);
  assign di_w = di_oe ? di_o : (h_oe ? h_di : 1'b0);
  always #2.5 clock_i = ~clock_i;
  ecl_loader #(.LOAD_WINDOW_CYC(2000)) dut (.clock_i(clock_i), .nrst_i(nrst_i),
    .eeprom_select_i(cs_w), .eeprom_select_o(cs_o), .eeprom_select_oe_o(cs_oe),
    .eeprom_serial_clock_i(sk_w), .eeprom_serial_clock_o(sk_o),
    .eeprom_serial_clock_oe_o(sk_oe), .eeprom_data_in_i(di_w), .eeprom_data_in_o(di_o),
    .eeprom_data_in_oe_o(di_oe), .eeprom_data_out_i(do_w), .port_vid_low_i(low),
    .port_default_vlan_id_o(port_default_vlan_id), .reserved_addr_forward_o(fwd),
    .vlan_group_count_sel_o(sel), .vlan_shift_o(shf), .frame_vid_i_unused_o(vsh),
    .strap_o(strap), .load_busy_o(busy), .frame_vid_i(fvid), .vlan_group_o(grp));
  ecl_eeprom_model u_ee (.cs_i(cs_w), .sk_i(sk_w), .di_i(di_w), .bad_sig_i(bad),
    .strap_do_i(sdo), .do_o(do_w));
  task automatic clk(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic conclude();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // reset with straps presented, release, wait for the load window
  task automatic boot(input logic sk, input logic di, input logic dout, input logic bs);
    nrst_i = 0;
    h_oe = 1;
    h_cs = 0;
    h_sk = sk;
    h_di = di;
    sdo = dout;
    bad = bs;
    r2a = 16'h0000;
    r2b = 16'h0000;
    r2c = ecl_pkg::RST_EXP_VLAN_CTRL;
    clk(8);
    nrst_i = 1;
    clk(100);
    h_oe = 0;
    sdo = 1;
    for (int i = 0; i < 70000 && busy !== 1'b0; i++) clk(1);
    if (busy !== 1'b0) begin
      cmp(busy, 0);
      conclude();
    end
    cmp(strap, {sk, di, dout});
  endtask
  // one host instruction in its own select cycle, trailing sk pulse
  task automatic ee_cmd(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d);
    logic [26:0] f;
    f = {1'b1, op, a, d};
    // idle gap so back-to-back commands never retoggle the bus in one step
    clk(4);
    h_oe = 1;
    h_cs = 1;
    for (int i = 26; i >= 0; i--) begin
      h_di = f[i];
      clk(4);
      h_sk = 1;
      clk(4);
      h_sk = 0;
    end
    clk(4);
    h_cs = 0;
    clk(4);
    h_sk = 1;
    clk(4);
    h_sk = 0;
    h_oe = 0;
    if (op == ecl_pkg::OP_WRITE && a == ecl_pkg::ADDR_PORT45_VID) r2a = d;
    if (op == ecl_pkg::OP_WRITE && a == ecl_pkg::ADDR_PORT67_VID) r2b = d;
    if (op == ecl_pkg::OP_WRITE && a == ecl_pkg::ADDR_EXP_VLAN_CTRL) r2c = d;
  endtask
  task automatic chk(input logic [11:0] v);
    logic [11:0] s;
    fvid = v;
    clk(12);
    cmp(port_default_vlan_id, {r2c[7:0], low[19:16], r2b[15:8], low[15:12], r2b[7:0], low[11:8],
      r2a[15:8], low[7:4], r2a[7:0], low[3:0]});
    cmp({fwd, sel, shf}, r2c[15:8]);
    s = v >> r2c[10:8];
    cmp(vsh, s);
    cmp(grp, r2c[11] ? s[4:0] : {1'b0, s[3:0]});
  endtask
  initial begin
    // reset falls on a clock edge so every flop sees its falling edge
    clk(1);
    boot(1, 1, 1, 0);
    r2a = 16'h8c3b;
    r2b = 16'h4e71;
    r2c = 16'h2a96;
    chk(12'hb6d);
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 8; s++) begin
        ee_cmd(2'b01, 8'h2c, {4'(s * 3 + m), 1'(m), 3'(s), 8'h5a});
        chk(12'h3a7 ^ 12'(s * 5 + m));
      end
    end
    ee_cmd(2'b01, 8'h2a, 16'h1f2e);
    ee_cmd(2'b01, 8'h2b, 16'h3d4c);
    low = 20'h5b6c7;
    chk(12'hfff);
    for (int op = 0; op < 4; op++) if (op != 1) ee_cmd(2'(op), 8'h2a, 16'hdead);
    chk(12'h0f0);
    $display("test load and snoop done");
    boot(0, 0, 1, 1);
    chk(12'h555);
    $display("test bad signature done");
    boot(0, 0, 0, 0);
    chk(12'h123);
    ee_cmd(2'b01, 8'h2b, 16'ha5c3);
    chk(12'h800);
    $display("test direct programming done");
    conclude();
  end
endmodule // tb_top
bind ecl_loader ecl_chk #(.LOAD_WINDOW_CYC(LOAD_WINDOW_CYC)) u_chk (.*);
